//--- pkg/rtc_pkg.sv
// Constants for the radio timer output, arm and transmit power command block.
// Assumes a 32-bit APB register bus and one 100 MHz system clock.
package rtc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_PARAM = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_USABLE = 8'h0C;
  localparam logic [7:0] OFF_ARMED = 8'h10;
  localparam logic [7:0] OFF_ROUTE1 = 8'h14;
  localparam logic [7:0] OFF_ROUTE2 = 8'h18;
  localparam logic [7:0] OFF_ROUTE3 = 8'h1C;
  localparam logic [7:0] OFF_POWER = 8'h20;
  localparam logic [7:0] OFF_APPLIED = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h2C;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h30;
  // ----------------------------------------
  // Command identifiers and result codes
  // ----------------------------------------
  localparam logic [15:0] ID_ROUTE = 16'h0604;
  localparam logic [15:0] ID_ARM = 16'h0409;
  localparam logic [15:0] ID_DISARM = 16'h040A;
  localparam logic [15:0] ID_POWER = 16'h0010;
  localparam logic [1:0] DIRECT_MARK = 2'h1;
  localparam logic [7:0] RES_PENDING = 8'h00;
  localparam logic [7:0] RES_DONE = 8'h01;
  localparam logic [7:0] RES_PAR_FAULT = 8'h81;
  localparam logic [7:0] RES_UNKNOWN = 8'h83;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SEL_LSB = 2;
  localparam int MODE_LSB = 5;
  localparam int CHAN_LSB = 8;
  localparam int BIAS_LSB = 0;
  localparam int GAIN_LSB = 6;
  localparam int BOOST_BIT = 8;
  localparam int COEF_LSB_V0 = 8;
  localparam int COEF_LSB_V1 = 9;
  localparam int REF_TEMP_C = 25;
  localparam int SLOPE_DIV = 256;
  localparam int SLOPE_SHIFT = $clog2(SLOPE_DIV);
  localparam logic [5:0] BIAS_MAX = 6'h3F;
  // ----------------------------------------
  // Output behaviour codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_PULSE = 3'b000,
    MODE_SET = 3'b001,
    MODE_CLEAR = 3'b010,
    MODE_TOGGLE = 3'b011,
    MODE_LOW = 3'b100,
    MODE_HIGH = 3'b101
  } rtc_mode_t;
  // ----------------------------------------
  // Interrupt bits and reset values
  // ----------------------------------------
  localparam int IRQ_CMD_DONE = 0;
  localparam int IRQ_POWER_APPLIED = 1;
  localparam int IRQ_COMPARE = 2;
  localparam int IRQ_BITS = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] RESET_POWER = 16'h0000;
endpackage

//--- logic/rtc_cmd_top.sv
// Command handler for timer output routing, channel arming and transmit power.
// Assumes an APB master on clk_sys_in, compare events from the radio timer on
// the same clock, and the transmit start strobe and temperature from elsewhere.
//
// Summary of operation
// - Route command 0x0604 takes config word; select bits 2-4, mode 5-7, channel 8-11.
// - Output select 1, 2, 3 name the three output events; others reserved.
// - Modes pulse, set, clear, toggle, low, high; compare of channel drives output.
// - Direct route command takes config bits 2-15 from command bits 2-15.
// - Route faults on reserved channel, select or mode, or on radio-owned output, else reports done.
// - Arm command 0x0409 arms channel given in parameter byte 2.
// - Disarm command 0x040A disarms channel given in parameter byte 2.
// - Direct arm or disarm reads channel from command bits 8-15.
// - Arm or disarm faults on reserved channel, else done after state change.
// - Power command 0x0010 takes a 16-bit power word from bytes 2-3.
// - First variant: bias 0-5, gain 6-7, slope 8-15; zero slope disables.
// - Second variant: bit 8 driver strength, slope bits 9-15.
// - At each transmit start bias equals base plus (temp-25) times slope over 256.
// - New power word takes effect only at the next transmit start.
// - Accepted power command always reports done.
// - A channel is usable only when its usable bitmap bit is one.
`timescale 1ns/1ps
module rtc_cmd_top #(
  parameter int CHANNELS = 8,
  parameter logic [7:0] USABLE_MASK = 8'hE0,
  parameter logic [2:0] RADIO_OUTPUTS = 3'h0,
  parameter int VARIANT = 0
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [CHANNELS-1:0] compare_event_in,
  input wire logic tx_start_in,
  input wire logic [7:0] temperature_in,
  output logic [CHANNELS-1:0] channel_armed_out,
  output logic [2:0] timer_output_event_out,
  output logic [5:0] pa_bias_code_out,
  output logic [1:0] first_stage_gain_out,
  output logic driver_strength_out,
  output logic irq_out
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  initial begin
    if (CHANNELS < 1 || CHANNELS > 8 || (VARIANT != 0 && VARIANT != 1)) begin
      $error("rtc_cmd_top: unsupported CHANNELS or VARIANT");
    end
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int IRQ_BITS_W = rtc_pkg::IRQ_BITS;
  logic [31:0] command_register;
  logic [31:0] param_word;
  logic cmd_go;
  logic [7:0] command_status_register;
  logic [CHANNELS-1:0] armed;
  logic [3:0] route_chan [3];
  logic [2:0] route_mode [3];
  logic [2:0] route_on;
  logic [2:0] gpo;
  logic [15:0] power_setting_word;
  logic [5:0] bias;
  logic [1:0] gain;
  logic boost;
  logic [IRQ_BITS_W-1:0] irq_status;
  logic [IRQ_BITS_W-1:0] irq_enable;
  logic irq;
  logic [31:0] rdata;
  logic ready;
  logic slverr;
  logic [7:0] temp_meta, temp_sync;
  logic tx_meta, tx_sync, tx_last;

  logic apb_take, wr_take, direct, is_route, is_arm, is_disarm, is_power;
  logic [15:0] cmd_id, cfg;
  logic [7:0] chan;
  logic chan_ok, sel_ok, mode_ok;
  logic [2:0] sel;
  logic [2:0] mode;
  logic [7:0] next_result;
  logic tx_edge;
  logic [CHANNELS-1:0] route_fire;
  logic [2:0] out_fire;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic usable(input logic [7:0] ch);
    usable = (ch < 8'(CHANNELS)) && USABLE_MASK[ch[2:0]];
  endfunction

  // Slope is eight bits wide; variant one has one bit less of it
  function automatic logic [5:0] comp_bias(input logic [15:0] w, input logic [7:0] t);
    logic signed [9:0] dt;
    logic signed [18:0] prod;
    logic signed [10:0] sum;
    dt = 10'($signed(t)) - 10'(rtc_pkg::REF_TEMP_C);
    prod = 19'(dt) * $signed({11'h000, (VARIANT == 0) ? w[15:8] : {1'b0, w[15:9]}});
    sum = 11'(w[5:0]) + 11'(prod >>> rtc_pkg::SLOPE_SHIFT);
    if (sum < 11'sh000) begin
      comp_bias = 6'h00;
    end else if (sum > 11'(rtc_pkg::BIAS_MAX)) begin
      comp_bias = rtc_pkg::BIAS_MAX;
    end else begin
      comp_bias = sum[5:0];
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      temp_meta <= 8'h00;
      temp_sync <= 8'h00;
      tx_meta <= 1'b0;
      tx_sync <= 1'b0;
      tx_last <= 1'b0;
    end else if (ce_in) begin
      temp_meta <= temperature_in;
      temp_sync <= temp_meta;
      tx_meta <= tx_start_in;
      tx_sync <= tx_meta;
      tx_last <= tx_sync;
    end
  end
  assign tx_edge = tx_sync & ~tx_last;

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  assign apb_take = psel_in & penable_in & ready;
  assign wr_take = apb_take & pwrite_in;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ready <= 1'b0;
      slverr <= 1'b0;
      rdata <= rtc_pkg::RESET_WORD;
    end else if (ce_in) begin
      ready <= psel_in & penable_in & ~ready;
      slverr <= 1'b0;
      rdata <= rtc_pkg::RESET_WORD;
      if (psel_in & penable_in & ~ready) begin
        if (paddr_in == rtc_pkg::OFF_COMMAND) begin
          rdata <= command_register;
        end else if (paddr_in == rtc_pkg::OFF_PARAM) begin
          rdata <= param_word;
        end else if (paddr_in == rtc_pkg::OFF_STATUS) begin
          rdata <= {24'h000000, command_status_register};
        end else if (paddr_in == rtc_pkg::OFF_USABLE) begin
          rdata <= {24'h000000, USABLE_MASK};
        end else if (paddr_in == rtc_pkg::OFF_ARMED) begin
          rdata <= 32'(armed);
        end else if (paddr_in == rtc_pkg::OFF_ROUTE1) begin
          rdata <= {20'h00000, route_chan[0], route_mode[0], 4'h0, route_on[0]};
        end else if (paddr_in == rtc_pkg::OFF_ROUTE2) begin
          rdata <= {20'h00000, route_chan[1], route_mode[1], 4'h0, route_on[1]};
        end else if (paddr_in == rtc_pkg::OFF_ROUTE3) begin
          rdata <= {20'h00000, route_chan[2], route_mode[2], 4'h0, route_on[2]};
        end else if (paddr_in == rtc_pkg::OFF_POWER) begin
          rdata <= {16'h0000, power_setting_word};
        end else if (paddr_in == rtc_pkg::OFF_APPLIED) begin
          rdata <= {23'h000000, boost, gain, bias};
        end else if (paddr_in == rtc_pkg::OFF_IRQ_STATUS) begin
          rdata <= 32'(irq_status);
        end else if (paddr_in == rtc_pkg::OFF_IRQ_CLEAR) begin
          rdata <= rtc_pkg::RESET_WORD;
        end else if (paddr_in == rtc_pkg::OFF_IRQ_ENABLE) begin
          rdata <= 32'(irq_enable);
        end else begin
          slverr <= 1'b1;
        end
      end
    end
  end

  // Writing the command word rings the doorbell
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      command_register <= rtc_pkg::RESET_WORD;
      param_word <= rtc_pkg::RESET_WORD;
      cmd_go <= 1'b0;
    end else if (ce_in) begin
      cmd_go <= wr_take && paddr_in == rtc_pkg::OFF_COMMAND;
      if (wr_take && paddr_in == rtc_pkg::OFF_COMMAND) begin
        command_register <= pwdata_in;
      end
      if (wr_take && paddr_in == rtc_pkg::OFF_PARAM) begin
        param_word <= pwdata_in;
      end
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  always_comb begin
    direct = command_register[1:0] == rtc_pkg::DIRECT_MARK;
    cmd_id = direct ? command_register[31:16] : param_word[15:0];
    cfg = direct ? {command_register[15:2], 2'b00} : param_word[31:16];
    chan = direct ? command_register[15:8] : param_word[23:16];
    is_route = cmd_id == rtc_pkg::ID_ROUTE;
    is_arm = cmd_id == rtc_pkg::ID_ARM;
    is_disarm = cmd_id == rtc_pkg::ID_DISARM;
    is_power = cmd_id == rtc_pkg::ID_POWER && !direct;
    sel = cfg[rtc_pkg::SEL_LSB +: 3];
    mode = cfg[rtc_pkg::MODE_LSB +: 3];
    sel_ok = sel >= 3'd1 && sel <= 3'd3 && !RADIO_OUTPUTS[2'(sel - 3'd1)];
    mode_ok = mode <= rtc_pkg::MODE_HIGH;
    chan_ok = is_route ? usable({4'h0, cfg[rtc_pkg::CHAN_LSB +: 4]}) : usable(chan);
    if (is_route) begin
      next_result = (chan_ok && sel_ok && mode_ok) ? rtc_pkg::RES_DONE : rtc_pkg::RES_PAR_FAULT;
    end else if (is_arm || is_disarm) begin
      next_result = chan_ok ? rtc_pkg::RES_DONE : rtc_pkg::RES_PAR_FAULT;
    end else if (is_power) begin
      next_result = rtc_pkg::RES_DONE;
    end else begin
      next_result = rtc_pkg::RES_UNKNOWN;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      command_status_register <= rtc_pkg::RES_DONE;
    end else if (ce_in) begin
      if (wr_take && paddr_in == rtc_pkg::OFF_COMMAND) begin
        command_status_register <= rtc_pkg::RES_PENDING;
      end else if (cmd_go) begin
        command_status_register <= next_result;
      end
    end
  end

  // ----------------------------------------
  // Arming; a command arm beats a same-cycle compare
  // ----------------------------------------
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      route_fire[c] = compare_event_in[c] & armed[c];
    end
    for (int k = 0; k < 3; k++) begin
      out_fire[k] = route_on[k] && route_chan[k] < 4'(CHANNELS) && route_fire[route_chan[k][2:0]];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      armed <= '0;
    end else if (ce_in) begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (cmd_go && is_arm && chan_ok && chan == 8'(c)) begin
          armed[c] <= 1'b1;
        end else if (cmd_go && is_disarm && chan_ok && chan == 8'(c)) begin
          armed[c] <= 1'b0;
        end else if (route_fire[c]) begin
          armed[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Output event routing
  // ----------------------------------------
  // Outputs move on a compare of an armed channel, or at once on a route to low or high; compare setup is software's job
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      route_on <= 3'h0;
      gpo <= 3'h0;
      for (int k = 0; k < 3; k++) begin
        route_chan[k] <= 4'h0;
        route_mode[k] <= rtc_pkg::MODE_LOW;
      end
    end else if (ce_in) begin
      for (int k = 0; k < 3; k++) begin
        if (route_mode[k] == rtc_pkg::MODE_PULSE) begin
          gpo[k] <= 1'b0;
        end
        if (cmd_go && is_route && chan_ok && sel_ok && mode_ok && sel == 3'(k + 1)) begin
          route_on[k] <= 1'b1;
          route_chan[k] <= cfg[rtc_pkg::CHAN_LSB +: 4];
          route_mode[k] <= mode;
          if (mode == rtc_pkg::MODE_LOW) begin
            gpo[k] <= 1'b0;
          end else if (mode == rtc_pkg::MODE_HIGH) begin
            gpo[k] <= 1'b1;
          end
        end else if (out_fire[k]) begin
          case (route_mode[k])
            rtc_pkg::MODE_PULSE: begin
              gpo[k] <= 1'b1;
            end
            rtc_pkg::MODE_SET: begin
              gpo[k] <= 1'b1;
            end
            rtc_pkg::MODE_CLEAR: begin
              gpo[k] <= 1'b0;
            end
            rtc_pkg::MODE_TOGGLE: begin
              gpo[k] <= ~gpo[k];
            end
            default: begin
              gpo[k] <= gpo[k];
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Transmit power
  // ----------------------------------------
  // The pending word is sampled at transmit start, so a packet in flight keeps its power
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      power_setting_word <= rtc_pkg::RESET_POWER;
      bias <= 6'h00;
      gain <= 2'h0;
      boost <= 1'b0;
    end else if (ce_in) begin
      if (cmd_go && is_power) begin
        power_setting_word <= param_word[31:16];
      end
      if (tx_edge) begin
        bias <= comp_bias(power_setting_word, temp_sync);
        gain <= power_setting_word[rtc_pkg::GAIN_LSB +: 2];
        boost <= (VARIANT == 1) && power_setting_word[rtc_pkg::BOOST_BIT];
      end
    end
  end

  // ----------------------------------------
  // Interrupts; hardware set beats a clear
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq <= 1'b0;
    end else if (ce_in) begin
      if (wr_take && paddr_in == rtc_pkg::OFF_IRQ_ENABLE) begin
        irq_enable <= pwdata_in[IRQ_BITS_W-1:0];
      end
      irq_status <= (irq_status & ~((wr_take && paddr_in == rtc_pkg::OFF_IRQ_CLEAR) ?
                    pwdata_in[IRQ_BITS_W-1:0] : 3'h0)) |
                    {|route_fire, tx_edge, cmd_go};
      irq <= |(irq_status & irq_enable);
    end
  end

  assign prdata_out = rdata;
  assign pready_out = ready;
  assign pslverr_out = slverr;
  assign channel_armed_out = armed;
  assign timer_output_event_out = gpo;
  assign pa_bias_code_out = bias;
  assign first_stage_gain_out = gain;
  assign driver_strength_out = boost;
  assign irq_out = irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_exec;
    cmd_go && ce_in;
  endsequence

  property p_route_cfg;
    @(posedge clk_sys_in) disable iff (reset_in)
    s_exec and is_route && next_result == rtc_pkg::RES_DONE |=>
      route_mode[2'($past(sel) - 3'd1)] == $past(mode) && route_on[2'($past(sel) - 3'd1)];
  endproperty
  a_route_cfg: assert property (p_route_cfg) else $error("route config not stored");

  property p_bad_sel;
    @(posedge clk_sys_in) disable iff (reset_in)
    s_exec and is_route && (sel == 3'd0 || sel > 3'd3 || !mode_ok) |=>
      command_status_register == rtc_pkg::RES_PAR_FAULT && $stable(route_on);
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("reserved code accepted");

  property p_const_high;
    @(posedge clk_sys_in) disable iff (reset_in)
    s_exec and is_route && next_result == rtc_pkg::RES_DONE && mode == rtc_pkg::MODE_HIGH |=>
      gpo[2'($past(sel) - 3'd1)];
  endproperty
  a_const_high: assert property (p_const_high) else $error("constant high not driven");

  property p_direct_cfg;
    @(posedge clk_sys_in) disable iff (reset_in)
    direct |-> cfg == {command_register[15:2], 2'b00} && chan == command_register[15:8];
  endproperty
  a_direct_cfg: assert property (p_direct_cfg) else $error("direct field mapping wrong");

  property p_arm;
    @(posedge clk_sys_in) disable iff (reset_in)
    s_exec and is_arm && chan_ok |=> armed[$past(chan[2:0])] ##0
      command_status_register == rtc_pkg::RES_DONE;
  endproperty
  a_arm: assert property (p_arm) else $error("channel not armed");

  property p_disarm;
    @(posedge clk_sys_in) disable iff (reset_in)
    s_exec and is_disarm && chan_ok |=> !armed[$past(chan[2:0])];
  endproperty
  a_disarm: assert property (p_disarm) else $error("channel not disarmed");

  property p_reserved_chan;
    @(posedge clk_sys_in) disable iff (reset_in)
    s_exec and (is_arm || is_disarm) && !usable(chan) |=>
      command_status_register == rtc_pkg::RES_PAR_FAULT && armed == ($past(armed) & ~$past(route_fire));
  endproperty
  a_reserved_chan: assert property (p_reserved_chan) else $error("reserved channel used");

  property p_power_done;
    @(posedge clk_sys_in) disable iff (reset_in)
    s_exec and is_power |=> command_status_register == rtc_pkg::RES_DONE ##0
      power_setting_word == $past(param_word[31:16]);
  endproperty
  a_power_done: assert property (p_power_done) else $error("power command not done");

  property p_hold_power;
    @(posedge clk_sys_in) disable iff (reset_in)
    ce_in && !tx_edge |=> $stable(bias) && $stable(gain) && $stable(boost);
  endproperty
  a_hold_power: assert property (p_hold_power) else $error("power changed mid packet");

  property p_zero_slope;
    @(posedge clk_sys_in) disable iff (reset_in)
    ce_in && tx_edge && power_setting_word[15:rtc_pkg::COEF_LSB_V1] == 7'h00 &&
      (VARIANT == 1 || !power_setting_word[rtc_pkg::COEF_LSB_V0]) |=>
      bias == $past(power_setting_word[5:0]);
  endproperty
  a_zero_slope: assert property (p_zero_slope) else $error("zero slope compensated");
endmodule

//--- sim/rtc_cpu_model.sv
// System processor model: drives APB cycles into the command block.
// Assumes the slave samples on the rising edge of clk_in.
`timescale 1ns/1ps
module rtc_cpu_model (
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire logic [31:0] prdata_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out
);
  initial begin
    psel_out = 1'h0;
    penable_out = 1'h0;
    pwrite_out = 1'h0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end
  // ----------------------------------------
  // Bus cycle
  // ----------------------------------------
  // Request held until pready; no fixed wait assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel_out <= 1'h1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'h1;
    // Sampled at the rising edge that completes the transfer, then released
    do @(posedge clk_in); while (pready_in !== 1'h1);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'h0;
    penable_out <= 1'h0;
  endtask
endmodule

//--- sim/rtc_cmd_top_test.sv
// Self-checking bench for the command block, random power words.
// Assumes the design in VARIANT 0 with default channel mask.
`timescale 1ns/1ps
module rtc_cmd_top_test;
  logic clk_sys_in = 1'h0;
  logic reset_in = 1'h1;
  logic psel, penable, pwrite, pready, pslverr, irq, drv, err;
  logic tx_start = 1'h0;
  logic [7:0] paddr, armed;
  logic [7:0] temp = 8'h00;
  logic [7:0] cmp = 8'h00;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] lfsr = 32'h000166F7;
  logic [15:0] w;
  logic [2:0] ev;
  logic [5:0] bias, pb;
  logic [1:0] gain, pg;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  rtc_cpu_model u_rtc_cpu_model (.clk_in(clk_sys_in), .pready_in(pready), .pslverr_in(pslverr),
    .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  rtc_cmd_top u_rtc_cmd_top (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(1'h1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .compare_event_in(cmp), .tx_start_in(tx_start), .temperature_in(temp),
    .channel_armed_out(armed), .timer_output_event_out(ev), .pa_bias_code_out(bias),
    .first_stage_gain_out(gain), .driver_strength_out(drv), .irq_out(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_rtc_cpu_model.xfer(1'h1, a, d, rd, err);
  endtask
  // Status read lands well after the result is posted
  task automatic cmd(input logic [31:0] p, input logic [31:0] c, input logic [7:0] res);
    wr(rtc_pkg::OFF_PARAM, p);
    wr(rtc_pkg::OFF_COMMAND, c);
    u_rtc_cpu_model.xfer(1'h0, rtc_pkg::OFF_STATUS, 32'h0, rd, err);
    @(negedge clk_sys_in);
    chk("status", {24'h0, rd[7:0]}, {24'h0, res});
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Floor division by 256, clamped to the field
  function automatic logic [5:0] exp_bias(input logic [15:0] pw, input logic [7:0] t);
    int v;
    v = int'(pw[5:0]) + (((int'($signed(t)) - 25) * int'(pw[15:8])) >>> 8);
    return (v < 0) ? 6'h00 : (v > 63) ? 6'h3F : v[5:0];
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_in);
    reset_in <= 1'h0;
    u_rtc_cpu_model.xfer(1'h0, rtc_pkg::OFF_USABLE, 32'h0, rd, err);
    chk("usable", rd, 32'hE0);
    u_rtc_cpu_model.xfer(1'h0, 8'h40, 32'h0, rd, err);
    chk("unmapped", {31'h0, err}, 32'h1);
    cmd({16'h0, 16'h1234}, 32'h0, rtc_pkg::RES_UNKNOWN);
    cmd({8'h00, 8'h05, rtc_pkg::ID_ARM}, 32'h0, rtc_pkg::RES_DONE);
    chk("armed", {24'h0, armed}, 32'h20);
    cmd(32'h0, {rtc_pkg::ID_DISARM, 8'h05, 8'h01}, rtc_pkg::RES_DONE);
    chk("armed", {24'h0, armed}, 32'h0);
    cmd({8'h00, 8'h02, rtc_pkg::ID_ARM}, 32'h0, rtc_pkg::RES_PAR_FAULT);
    cmd(32'h0, {rtc_pkg::ID_ARM, 8'h08, 8'h01}, rtc_pkg::RES_PAR_FAULT);
    cmd(32'h0, {rtc_pkg::ID_ROUTE, 16'h05A5}, rtc_pkg::RES_DONE);
    chk("out1", {31'h0, ev[0]}, 32'h1);
    cmd(32'h0, {rtc_pkg::ID_ROUTE, 16'h02A5}, rtc_pkg::RES_PAR_FAULT);
    for (int s = 0; s < 8; s++) begin
      cmd({16'h07A0 | 16'(s << 2), rtc_pkg::ID_ROUTE}, 32'h0,
          (s > 0 && s < 4) ? rtc_pkg::RES_DONE : rtc_pkg::RES_PAR_FAULT);
    end
    chk("outs", {29'h0, ev}, 32'h7);
    for (int m = 0; m < 8; m++) begin
      cmd({16'h070C | 16'(m << 5), rtc_pkg::ID_ROUTE}, 32'h0,
          (m < 6) ? rtc_pkg::RES_DONE : rtc_pkg::RES_PAR_FAULT);
      // Pulse mode idles low, so set, clear, toggle and low keep it low until constant high
      chk("out3", {31'h0, ev[2]}, (m >= 5) ? 32'h1 : 32'h0);
    end
    // Compare mode of channel 6 is set up outside this block
    cmd({8'h00, 8'h06, rtc_pkg::ID_ARM}, 32'h0, rtc_pkg::RES_DONE);
    cmd({16'h0668, rtc_pkg::ID_ROUTE}, 32'h0, rtc_pkg::RES_DONE);
    wr(rtc_pkg::OFF_IRQ_CLEAR, 32'h7);
    wr(rtc_pkg::OFF_IRQ_ENABLE, 32'h4);
    cmp <= 8'h40;
    @(posedge clk_sys_in);
    cmp <= 8'h00;
    repeat (3) @(negedge clk_sys_in);
    chk("toggle", {31'h0, ev[1]}, 32'h0);
    chk("armed", {24'h0, armed}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(rtc_pkg::OFF_IRQ_CLEAR, 32'h7);
    repeat (2) @(negedge clk_sys_in);
    chk("irq", {31'h0, irq}, 32'h0);
    cmd(32'h0, {rtc_pkg::ID_DISARM, 8'h06, 8'h01}, rtc_pkg::RES_DONE);
    chk("irq", {31'h0, irq}, 32'h0);
    pb = 6'h00;
    pg = 2'h0;
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      w = lfsr[15:0];
      if (i == 0) w[15:8] = 8'h00;
      temp <= lfsr[23:16];
      cmd({w, rtc_pkg::ID_POWER}, 32'h0, rtc_pkg::RES_DONE);
      chk("bias_hold", {26'h0, bias}, {26'h0, pb});
      @(posedge clk_sys_in);
      tx_start <= 1'h1;
      repeat (6) @(posedge clk_sys_in);
      tx_start <= 1'h0;
      repeat (2) @(negedge clk_sys_in);
      pb = exp_bias(w, temp);
      pg = w[7:6];
      chk("bias", {26'h0, bias}, {26'h0, pb});
      chk("gain", {30'h0, gain}, {30'h0, pg});
      chk("drive", {31'h0, drv}, 32'h0);
    end
    test_done();
  end
endmodule
